/* File: hw/pmwr_pkg.sv */
// Function
// [RULE1] wake flag bit0 write sets capsense wake enable
// [RULE2] wake flag bit0 reads capsense wake cause
// [RULE3] flags set block low power, keep oscillator
// [RULE4] software clears wake flags after reset, wake
// [RULE5] flags read zero two clocks after suspend
// [RULE6] mode bit7 enables buffered rtc output
// [RULE7] mode bit6 gates wake request output pin
// [RULE8] mode bit5 write one disables supply monitor
// [RULE9] mode bits 4:0 read zero, ignore writes
// [RULE10] control bits 7:2 are general flags
// [RULE11] control bit1 write one enters stop mode
// [RULE12] control bit0 write one enters idle mode
// [RULE13] wake flag bits 7:1 read zero always
// [RULE14] leaving sleep drives wake request low
// [RULE15] monitor disabled: any reset is full por
// [RULE16] wake flags record events at all times
// [RULE17] capsense flag holds until clear-all command
package pmwr_pkg;
   // register addresses on the special function register bus
   localparam logic [7:0] power_control_addr   = 8'h87;
   localparam logic [7:0] wake_flag_extra_addr = 8'hce; // sfr page 0x0
   localparam logic [7:0] power_unit_mode_addr = 8'hce; // sfr page 0xf
   localparam logic [3:0] page_flag            = 4'h0;
   localparam logic [3:0] page_mode            = 4'hf;
   // field positions
   localparam int ctl_idle_bit   = 0;
   localparam int ctl_stop_bit   = 1;
   localparam int ctl_gpf_lsb    = 2;
   localparam int mode_mon_dis   = 5;
   localparam int mode_wake_out  = 6;
   localparam int mode_rtc_out   = 7;
   localparam int flag_cs_bit    = 0;
   // reset values
   localparam logic [5:0] gpf_reset   = 6'h00;
   localparam logic [2:0] mode_reset  = 3'h0;
   // flags read as zero for this many clocks after a suspend wake
   localparam int          wake_blank_clocks = 2;
   localparam logic [1:0]  wake_blank_count  = 2'(wake_blank_clocks);
   // one sfr access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmwr_sfr_req_t;
   // power state seen from the sequencer
   typedef struct packed {
      logic in_sleep;
      logic in_suspend;
      logic wake_now;   // one-cycle pulse at wake
   } pmwr_pwr_stat_t;
endpackage

/* File: hw/pmwr_regs.sv */
`timescale 1ns/10ps
module pmwr_regs (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire pmwr_pkg::pmwr_sfr_req_t  sfr_req,          // core access
   output logic      [7:0]               sfr_rdata,        // registered read data
   input  wire pmwr_pkg::pmwr_pwr_stat_t pwr_stat,         // from power sequencer
   input  wire logic                     capsense_event,   // capsense pulse
   input  wire logic                     clear_all_flags,  // clear command pulse
   input  wire logic                     reset_source,     // any reset source pulse
   input  wire logic                     rtc_clock_in,     // buffered rtc oscillator
   output logic                          capsense_wake_req,// enabled wake to sequencer
   output logic                          idle_req,         // one-cycle pulse
   output logic                          stop_req,         // one-cycle pulse
   output logic                          low_power_block,  // refuse suspend or sleep
   output logic                          lposc_force_on,   // keep low power oscillator
   output logic                          rtc_pin_out,      // port pin data
   output logic                          rtc_pin_en,       // port pin takeover
   output logic                          wake_pin_out,     // wake request level
   output logic                          wake_pin_en,      // port pin takeover
   output logic                          supply_mon_on,    // supply monitor enable
   output logic                          full_por_req      // escalate reset to por
);
   import pmwr_pkg::*;

   // register state
   logic [5:0] gpf_reg;          // general purpose flags
   logic       cs_en_reg;        // capsense wake enable
   logic       cs_flag_reg;      // capsense wake flag
   logic       rtc_out_en_reg;   // buffered rtc output enable
   logic       wake_out_en_reg;  // wake request output enable
   logic       mon_dis_reg;      // supply monitor disabled
   logic [1:0] blank_reg;        // post-suspend flag blanking count
   logic [7:0] rdata_next;       // read mux result
   // address hits
   logic       ctl_hit;          // control register, any page
   logic       flg_hit;          // wake flag register, page 0x0
   logic       mod_hit;          // mode register, page 0xf
   // qualified access strobes
   logic       ctl_wr;           // control write
   logic       flg_wr;           // wake flag write
   logic       mod_wr;           // mode write
   logic       ctl_rd;           // control read
   logic       flg_rd;           // wake flag read
   logic       mod_rd;           // mode read
   // derived conditions
   logic       wake_suspend;     // wake out of suspend this cycle
   logic       flag_visible;     // flag as software sees it

   // address and page decode; flag and mode share one address,
   // so the page select is part of their hit
   assign ctl_hit = sfr_req.addr == power_control_addr;
   assign flg_hit = sfr_req.addr == wake_flag_extra_addr && sfr_req.page == page_flag;
   assign mod_hit = sfr_req.addr == power_unit_mode_addr && sfr_req.page == page_mode;

   // write strobes
   assign ctl_wr = sfr_req.wr && ctl_hit;
   assign flg_wr = sfr_req.wr && flg_hit;
   assign mod_wr = sfr_req.wr && mod_hit;

   // read strobes
   assign ctl_rd = sfr_req.rd && ctl_hit;
   assign flg_rd = sfr_req.rd && flg_hit;
   assign mod_rd = sfr_req.rd && mod_hit;

   // only a wake out of suspend blanks the flags; sleep wakes do not
   assign wake_suspend = pwr_stat.wake_now && pwr_stat.in_suspend;

   // flag hidden while the blanking count runs
   assign flag_visible = cs_flag_reg && blank_reg == 2'h0; // [RULE5]

   // general purpose flags simply store the written value
   always_ff @(posedge clk) begin
      if (rst) begin
         gpf_reg <= gpf_reset;
      end else if (ctl_wr) begin
         // stored on any page, the register is unpaged
         gpf_reg <= sfr_req.wdata[7:ctl_gpf_lsb]; // [RULE10]
      end
   end

   // idle and stop select bits are write-only strobes, nothing stored;
   // the sequencer acts on the pulse, so a read has nothing to return
   always_ff @(posedge clk) begin
      if (rst) begin
         idle_req <= 1'h0;
         stop_req <= 1'h0;
      end else begin
         idle_req <= ctl_wr && sfr_req.wdata[ctl_idle_bit]; // [RULE12]
         stop_req <= ctl_wr && sfr_req.wdata[ctl_stop_bit]; // [RULE11]
      end
   end

   // capsense wake enable; only bit 0 of the flag register is writable,
   // the upper bits have no storage at all
   always_ff @(posedge clk) begin
      if (rst) begin
         cs_en_reg <= 1'h0;
      end else if (flg_wr) begin
         cs_en_reg <= sfr_req.wdata[flag_cs_bit]; // [RULE1]
      end
   end

   // flag records events whether enabled or not, awake or not;
   // set beats clear so an event racing the clear is never lost
   always_ff @(posedge clk) begin
      if (rst) begin
         cs_flag_reg <= 1'h0;
      end else if (capsense_event) begin
         cs_flag_reg <= 1'h1; // [RULE16]
      end else if (clear_all_flags) begin
         // only the clear-all command drops it, a write of zero does not
         cs_flag_reg <= 1'h0; // [RULE17]
      end
   end

   // blanking counter restarts on every suspend wake
   always_ff @(posedge clk) begin
      if (rst) begin
         blank_reg <= 2'h0;
      end else if (wake_suspend) begin
         blank_reg <= wake_blank_count; // [RULE5]
      end else if (blank_reg != 2'h0) begin
         // counts down to zero and rests there
         blank_reg <= blank_reg - 2'h1;
      end
   end

   // mode register; the monitor bit is also cleared by any reset source,
   // which wins over a write so the monitor always comes back
   always_ff @(posedge clk) begin
      if (rst) begin
         rtc_out_en_reg  <= mode_reset[2];
         wake_out_en_reg <= mode_reset[1];
         mon_dis_reg     <= mode_reset[0];
      end else if (reset_source) begin
         mon_dis_reg <= 1'h0; // [RULE15]
      end else if (mod_wr) begin
         rtc_out_en_reg  <= sfr_req.wdata[mode_rtc_out]; // [RULE6]
         wake_out_en_reg <= sfr_req.wdata[mode_wake_out]; // [RULE7]
         mon_dis_reg     <= sfr_req.wdata[mode_mon_dis]; // [RULE8]
      end
   end

   // read mux; unused bits and unmapped addresses read zero
   always_comb begin
      rdata_next = 8'h00;
      if (ctl_rd) begin
         // select bits have no read value, zero is returned
         rdata_next = {gpf_reg, 2'h0}; // [RULE10]
      end else if (flg_rd) begin
         // blanked shortly after suspend wake, upper bits zero
         rdata_next = {7'h00, flag_visible}; // [RULE2] [RULE13]
      end else if (mod_rd) begin
         // low five bits have no storage and read zero
         rdata_next = {rtc_out_en_reg, wake_out_en_reg, mon_dis_reg, 5'h00}; // [RULE9]
      end
   end

   // read data is registered, valid the cycle after the read strobe
   // and zero otherwise, so a stale value never lingers on the bus
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= rdata_next;
      end
   end

   // wake request to the sequencer, only when enabled and flagged
   always_ff @(posedge clk) begin
      if (rst) begin
         capsense_wake_req <= 1'h0;
      end else begin
         capsense_wake_req <= cs_en_reg && cs_flag_reg; // [RULE1]
      end
   end

   // a set flag refuses low power and keeps the oscillator on;
   // the flag counts here whether enabled or not
   always_ff @(posedge clk) begin
      if (rst) begin
         low_power_block <= 1'h0;
         lposc_force_on  <= 1'h0;
      end else begin
         low_power_block <= cs_flag_reg; // [RULE3]
         lposc_force_on  <= cs_flag_reg; // [RULE3]
      end
   end

   // buffered rtc oscillator onto its port pin; the clock is only
   // sampled, so edges closer than one system clock can be lost
   always_ff @(posedge clk) begin
      if (rst) begin
         rtc_pin_out <= 1'h0;
         rtc_pin_en  <= 1'h0;
      end else begin
         rtc_pin_out <= rtc_out_en_reg && rtc_clock_in; // [RULE6]
         rtc_pin_en  <= rtc_out_en_reg; // [RULE6]
      end
   end

   // wake request pin: high while asleep, low from the wake onward so
   // that external devices wake too; gated onto the pin by its enable
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_pin_out <= 1'h1;
         wake_pin_en  <= 1'h0;
      end else begin
         wake_pin_out <= pwr_stat.in_sleep && !pwr_stat.wake_now; // [RULE14]
         wake_pin_en  <= wake_out_en_reg; // [RULE7]
      end
   end

   // supply monitor and reset escalation; a reset source seen while the
   // monitor is off becomes a full power-on reset
   always_ff @(posedge clk) begin
      if (rst) begin
         supply_mon_on <= 1'h1;
         full_por_req  <= 1'h0;
      end else begin
         supply_mon_on <= !mon_dis_reg; // [RULE8]
         full_por_req  <= reset_source && mon_dis_reg; // [RULE15]
      end
   end
endmodule

/* File: verification/pmwr_core_model.sv */
`timescale 1ns/10ps
module pmwr_core_model (
   input  wire logic               clk,
   output pmwr_pkg::pmwr_sfr_req_t sfr_req,
   input  wire logic [7:0]         sfr_rdata
);
   import pmwr_pkg::*;
   initial sfr_req = '0;
   // one strobe cycle, then an idle cycle so results land
   task automatic access(input logic w, input logic [3:0] p, input logic [7:0] a, d,
                         output logic [7:0] q);
      sfr_req = '{wr: w, rd: !w, page: p, addr: a, wdata: d};
      @(posedge clk);
      #1 q = sfr_rdata;
      // released lines carry junk, never the old value
      sfr_req = '{wr: 1'b0, rd: 1'b0, page: ~p, addr: ~a, wdata: ~d};
      @(posedge clk);
      #1;
   endtask
endmodule

/* File: verification/pmwr_regs_bench.sv */
`timescale 1ns/10ps
module pmwr_regs_bench;
   import pmwr_pkg::*;
   logic           clk, rst, ev, clr, rsrc, rtc;
   pmwr_sfr_req_t  req;
   pmwr_pwr_stat_t stat;
   logic [7:0]     rdata, q;
   logic           wreq, idl, stp, lpb, osc, rpo, rpe, wpo, wpe, mon, por;
   int             miscompares = 0, num_checks = 0;
   int             idle_cnt = 0, stop_cnt = 0, por_cnt = 0; // strobe pulses seen
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count one-cycle strobes; a strobe held too long counts twice
   always @(posedge clk) begin
      if (idl === 1'h1) begin
         idle_cnt <= idle_cnt + 1;
      end
      if (stp === 1'h1) begin
         stop_cnt <= stop_cnt + 1;
      end
      if (por === 1'h1) begin
         por_cnt <= por_cnt + 1;
      end
   end
   pmwr_core_model i_pmwr_core_model (.clk(clk), .sfr_req(req), .sfr_rdata(rdata));
   pmwr_regs i_pmwr_regs (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
      .pwr_stat(stat), .capsense_event(ev), .clear_all_flags(clr), .reset_source(rsrc),
      .rtc_clock_in(rtc), .capsense_wake_req(wreq), .idle_req(idl), .stop_req(stp),
      .low_power_block(lpb), .lposc_force_on(osc), .rtc_pin_out(rpo), .rtc_pin_en(rpe),
      .wake_pin_out(wpo), .wake_pin_en(wpe), .supply_mon_on(mon), .full_por_req(por));
   task automatic chk(input string n, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] p, input logic [7:0] a, d);
      i_pmwr_core_model.access(1'b1, p, a, d, q);
   endtask
   task automatic rdc(input logic [3:0] p, input logic [7:0] a, e, input string n);
      i_pmwr_core_model.access(1'b0, p, a, 8'h00, q);
      chk(n, e, q);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {rst, ev, clr, rsrc, rtc} = 5'h10;
      stat = '0;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      chk("pins", 8'h03, {6'h0, wpo, mon});
      pulse(clr);
      rdc(4'h0, 8'h87, 8'h00, "ctl");
      rdc(4'hf, 8'hce, 8'h00, "mode");
      $display("done reset");
      wr(4'h3, 8'h87, 8'hab);
      rdc(4'h0, 8'h87, 8'ha8, "ctl");
      chk("idle", 8'h01, 8'(idle_cnt));
      chk("stop", 8'h01, 8'(stop_cnt));
      // idle alone on another page: stop must stay quiet
      wr(4'h0, 8'h87, 8'hfd);
      rdc(4'h7, 8'h87, 8'hfc, "ctl");
      chk("idle", 8'h02, 8'(idle_cnt));
      chk("stop", 8'h01, 8'(stop_cnt));
      rtc = 1'b1;
      wr(4'hf, 8'hce, 8'hff);
      rdc(4'hf, 8'hce, 8'he0, "mode");
      chk("pins", 8'h0e, {4'h0, rpo, rpe, wpe, mon});
      pulse(rsrc);
      rdc(4'hf, 8'hce, 8'hc0, "mode");
      chk("mon", 8'h01, {7'h0, mon});
      chk("por", 8'h01, 8'(por_cnt));
      $display("done mode");
      wr(4'h0, 8'hce, 8'h01);
      rdc(4'h0, 8'hce, 8'h00, "flag");
      pulse(ev);
      rdc(4'h0, 8'hce, 8'h01, "flag");
      chk("outs", 8'h07, {5'h0, wreq, lpb, osc});
      wr(4'h0, 8'hce, 8'hfe);
      chk("outs", 8'h01, {6'h0, wreq, lpb});
      pulse(clr);
      rdc(4'h0, 8'hce, 8'h00, "flag");
      chk("block", 8'h00, {7'h0, lpb});
      $display("done flag");
      stat = '{in_sleep: 1'b1, in_suspend: 1'b1, wake_now: 1'b0};
      pulse(ev);
      @(posedge clk);
      #1 stat.wake_now = 1'b1;
      chk("wake pin", 8'h01, {7'h0, wpo});
      @(posedge clk);
      #1 stat = '0;
      rdc(4'h0, 8'hce, 8'h00, "blank");
      rdc(4'h0, 8'hce, 8'h01, "flag");
      chk("wake pin", 8'h00, {7'h0, wpo});
      // reset source with the monitor on must not escalate
      pulse(rsrc);
      rdc(4'hf, 8'hce, 8'hc0, "mode");
      chk("por", 8'h01, 8'(por_cnt));
      pulse(clr);
      $display("done wake");
      complete_run;
   end
   // hang guard
   initial begin
      #100000;
      miscompares++;
      complete_run;
   end
endmodule

/* File: verification/pmwr_regs_monitor.sv */
`timescale 1ns/10ps
module pmwr_regs_monitor (
   input wire logic                     clk,
   input wire logic                     rst,
   input wire pmwr_pkg::pmwr_sfr_req_t  sfr_req,
   input wire logic [7:0]               sfr_rdata,
   input wire pmwr_pkg::pmwr_pwr_stat_t pwr_stat,
   input wire logic                     capsense_event,
   input wire logic                     clear_all_flags,
   input wire logic                     reset_source,
   input wire logic                     idle_req,
   input wire logic                     stop_req,
   input wire logic                     low_power_block,
   input wire logic                     lposc_force_on,
   input wire logic                     wake_pin_out,
   input wire logic                     supply_mon_on,
   input wire logic                     full_por_req
);
   import pmwr_pkg::*;
   logic wr87, rdf, rdm; // decoded core accesses
   assign wr87 = sfr_req.wr && sfr_req.addr == 8'h87;
   assign rdf = sfr_req.rd && sfr_req.addr == 8'hce && sfr_req.page == 4'h0;
   assign rdm = sfr_req.rd && sfr_req.addr == 8'hce && sfr_req.page == 4'hf;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_IDLE: assert property (wr87 && sfr_req.wdata[0] |-> ##[1:2] idle_req)
      else $error("idle pulse missing");
   AST_STOP: assert property (wr87 && sfr_req.wdata[1] |-> ##[1:2] stop_req)
      else $error("stop pulse missing");
   AST_FLAG_HI: assert property (rdf |=> sfr_rdata[7:1] == 7'h00)
      else $error("flag upper bits set");
   AST_MODE_LO: assert property (rdm |=> sfr_rdata[4:0] == 5'h00)
      else $error("mode low bits set");
   AST_WAKE: assert property (pwr_stat.wake_now |=> !wake_pin_out)
      else $error("wake pin not low");
   AST_POR: assert property (full_por_req |-> !supply_mon_on && $past(reset_source))
      else $error("por without cause");
   AST_MON_BACK: assert property (full_por_req |-> ##[1:2] supply_mon_on)
      else $error("monitor not back");
   AST_BLOCK: assert property (capsense_event |-> ##[1:3] low_power_block)
      else $error("event not blocking");
   AST_OSC: assert property (low_power_block |-> lposc_force_on)
      else $error("oscillator not held");
   AST_HOLD: assert property (low_power_block && !clear_all_flags && !$past(clear_all_flags)
      |=> low_power_block) else $error("flag lost");
   // a clear with no event in the same cycle drops the block two edges on
   AST_CLEAR: assert property (clear_all_flags && !capsense_event
      |-> ##2 !low_power_block) else $error("flag not cleared");
   // flag reads in the first two clocks after a suspend wake return zero
   AST_BLANK: assert property (pwr_stat.wake_now && pwr_stat.in_suspend ##[1:2] rdf
      |=> sfr_rdata[0] == 1'h0) else $error("flag not blanked");
endmodule
bind pmwr_regs pmwr_regs_monitor i_mon (.clk(clk), .rst(rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .pwr_stat(pwr_stat), .capsense_event(capsense_event),
   .clear_all_flags(clear_all_flags), .reset_source(reset_source), .idle_req(idle_req),
   .stop_req(stop_req), .low_power_block(low_power_block), .lposc_force_on(lposc_force_on),
   .wake_pin_out(wake_pin_out), .supply_mon_on(supply_mon_on), .full_por_req(full_por_req));
